// ===== hw/epm_amp.sv
// Sum of squares of one sine/cosine pair about mid-scale, with a window check.
`timescale 1ns/10ps
module epm_amp
  import epm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADC_W-1:0] sin_s,
  input wire logic [ADC_W-1:0] cos_s,
  input wire logic [AMP_W-1:0] amp_lo,
  input wire logic [AMP_W-1:0] amp_hi,
  output logic [AMP_W-1:0] amp,
  output logic bad
);
  logic signed [ADC_W:0] s_c;
  logic signed [ADC_W:0] c_c;
  logic signed [AMP_W:0] s_w;
  logic signed [AMP_W:0] c_w;
  logic [AMP_W-1:0] amp_d;
  logic [AMP_W-1:0] amp_q;
  logic bad_d;
  logic bad_q;

  always_comb begin
    s_c = $signed({1'b0, sin_s}) - $signed({1'b0, ADC_MID});
    c_c = $signed({1'b0, cos_s}) - $signed({1'b0, ADC_MID});
    s_w = (AMP_W+1)'(s_c);
    c_w = (AMP_W+1)'(c_c);
    // Squares are formed at full width, since a product at sample width would lose its top.
    amp_d = AMP_W'(s_w * s_w) + AMP_W'(c_w * c_w);
    // A broken wire pins a channel, which pushes the sum out of the window.
    bad_d = (amp_q < amp_lo) || (amp_q > amp_hi);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_q <= '0;
      bad_q <= 1'b0;
    end else begin
      amp_q <= amp_d;
      bad_q <= bad_d;
    end
  end

  assign amp = amp_q;
  assign bad = bad_q;
endmodule

// ===== hw/epm_top.sv
// Encoder position monitor: quadrature counting, positions, samples and wire faults.
`timescale 1ns/10ps
module epm_top
  import epm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [2:0] uvw_in,
  input wire logic sample_valid,
  input wire epm_samples_t samples_in,
  input wire logic [15:0] elec_angle_in,
  input wire logic motor_stopped,
  input wire logic fault_clear,
  input wire logic [AMP_W-1:0] amp_lo,
  input wire logic [AMP_W-1:0] amp_hi,
  input wire logic [15:0] enc_lines,
  input wire logic [7:0] pole_pairs,
  output logic [CNT_W-1:0] encoder_pulse_count,
  output logic [POS13_W-1:0] rotor_position_13bit,
  output logic [POS16_W-1:0] rotor_position_16bit,
  output logic [AMP_W-1:0] ab_pair_amplitude,
  output logic [AMP_W-1:0] cd_pair_amplitude,
  output logic ab_synthesis_fault,
  output logic cd_synthesis_fault,
  output logic [15:0] no_load_tuning_check_value,
  output epm_samples_t samples_out,
  output logic [2:0] commutation_state,
  output logic [15:0] electrical_angle_value
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  logic [1:0] ab_old_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
      ab_old_q <= '0;
    end else begin
      sy1_q <= {uvw_in, enc_b, enc_a};
      sy2_q <= sy1_q;
      ab_old_q <= sy2_q[1:0];
    end
  end

  // ----------------------------------------
  // Start-up guard
  // ----------------------------------------
  // The pipe above resets to zero whatever level the pins hold, so a pin that idles high would
  // look like an edge once it arrives; counting waits until the edge memory holds pin levels.
  logic arm1_d;
  logic arm1_q;
  logic arm2_d;
  logic arm2_q;
  logic arm3_d;
  logic arm3_q;
  always_comb begin
    arm1_d = 1'b1;
    arm2_d = arm1_q;
    arm3_d = arm2_q;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arm1_q <= 1'b0;
      arm2_q <= 1'b0;
      arm3_q <= 1'b0;
    end else begin
      arm1_q <= arm1_d;
      arm2_q <= arm2_d;
      arm3_q <= arm3_d;
    end
  end

  // ----------------------------------------
  // Quadrature decode and positions
  // ----------------------------------------
  logic step;
  logic up;
  logic [1:0] ab_new;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_q;
  logic [POS13_W-1:0] p13_d;
  logic [POS13_W-1:0] p13_q;
  logic [POS16_W-1:0] p16_d;
  logic [POS16_W-1:0] p16_q;

  always_comb begin
    ab_new = sy2_q[1:0];
    // Every edge of either channel is one count; both changing at once is a glitch.
    step = arm3_q & ((ab_new[0] ^ ab_old_q[0]) ^ (ab_new[1] ^ ab_old_q[1]));
    up = ab_new[1] ^ ab_old_q[0];
    cnt_d = cnt_q;
    p13_d = p13_q;
    p16_d = p16_q;
    if (step) begin
      if (up) begin
        cnt_d = cnt_q + CNT_W'(1);
        p13_d = p13_q + POS13_W'(1);
        p16_d = p16_q + POS16_W'(POS16_STEP);
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
        p13_d = p13_q - POS13_W'(1);
        p16_d = p16_q - POS16_W'(POS16_STEP);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= CNT_ZERO;
      p13_q <= POS13_ZERO;
      p16_q <= POS16_ZERO;
    end else begin
      cnt_q <= cnt_d;
      p13_q <= p13_d;
      p16_q <= p16_d;
    end
  end

  // ----------------------------------------
  // Sample capture
  // ----------------------------------------
  epm_samples_t smp_d, smp_q;
  logic [2:0] uvw_d, uvw_q;
  logic [15:0] ang_d, ang_q;
  always_comb begin
    smp_d = sample_valid ? samples_in : smp_q;
    ang_d = sample_valid ? elec_angle_in : ang_q;
    uvw_d = sy2_q[4:2];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      smp_q <= '0;
      uvw_q <= '0;
      ang_q <= '0;
    end else begin
      smp_q <= smp_d;
      uvw_q <= uvw_d;
      ang_q <= ang_d;
    end
  end

  // ----------------------------------------
  // Amplitudes and faults
  // ----------------------------------------
  logic ab_bad;
  logic cd_bad;
  logic ab_f_d;
  logic ab_f_q;
  logic cd_f_d;
  logic cd_f_q;
  logic cd_pend_d;
  logic cd_pend_q;
  epm_amp u_ab (
    .clk(clk),
    .resetn(resetn),
    .sin_s(smp_q.a),
    .cos_s(smp_q.b),
    .amp_lo(amp_lo),
    .amp_hi(amp_hi),
    .amp(ab_pair_amplitude),
    .bad(ab_bad)
  );
  epm_amp u_cd (
    .clk(clk),
    .resetn(resetn),
    .sin_s(smp_q.c),
    .cos_s(smp_q.d),
    .amp_lo(amp_lo),
    .amp_hi(amp_hi),
    .amp(cd_pair_amplitude),
    .bad(cd_bad)
  );
  always_comb begin
    // Set wins over clear so a fault seen during the clear is kept.
    ab_f_d = ab_bad | (ab_f_q & ~fault_clear);
    cd_pend_d = cd_bad | (cd_pend_q & ~fault_clear);
    cd_f_d = (cd_pend_q & motor_stopped) | (cd_f_q & ~fault_clear);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ab_f_q <= 1'b0;
      cd_f_q <= 1'b0;
      cd_pend_q <= 1'b0;
    end else begin
      ab_f_q <= ab_f_d;
      cd_f_q <= cd_f_d;
      cd_pend_q <= cd_pend_d;
    end
  end

  // ----------------------------------------
  // Tuning check value
  // ----------------------------------------
  logic [23:0] tnum;
  logic [15:0] tden;
  logic [15:0] tune_d, tune_q;
  always_comb begin
    tnum = 24'(enc_lines) * 24'(TUNE_NUM);
    tden = 16'(pole_pairs) * 16'(TUNE_DEN);
    // A divider is costly but these inputs are static configuration.
    tune_d = (tden == 16'h0000) ? 16'h0000 : 16'(tnum / 24'(tden));
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tune_q <= '0;
    end else begin
      tune_q <= tune_d;
    end
  end

  assign encoder_pulse_count = cnt_q;
  assign rotor_position_13bit = p13_q;
  assign rotor_position_16bit = p16_q;
  assign ab_synthesis_fault = ab_f_q;
  assign cd_synthesis_fault = cd_f_q;
  assign no_load_tuning_check_value = tune_q;
  assign samples_out = smp_q;
  assign commutation_state = uvw_q;
  assign electrical_angle_value = ang_q;
endmodule

// ===== inc/epm_pkg.sv
// Constants and types for the encoder position monitor.
package epm_pkg;
  localparam int ADC_W = 12;
  localparam int POS13_W = 13;
  localparam int POS16_W = 16;
  localparam int CNT_W = 32;
  localparam int AMP_W = 2 * ADC_W + 1;
  localparam int POS16_STEP = 8;
  localparam int TUNE_NUM = 4;
  localparam int TUNE_DEN = 6;
  localparam logic [ADC_W-1:0] ADC_MID = 12'h800;
  localparam logic [POS13_W-1:0] POS13_ZERO = 13'h0000;
  localparam logic [POS16_W-1:0] POS16_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [ADC_W-1:0] a;
    logic [ADC_W-1:0] b;
    logic [ADC_W-1:0] c;
    logic [ADC_W-1:0] d;
  } epm_samples_t;
endpackage

// ===== tb/epm_enc_model.sv
// Shaft encoder model giving one quadrature edge per step request.
`timescale 1ns/10ps
module epm_enc_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step,
  input wire logic dir,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_q = 2'h0;
  // Gray order keeps one pin moving per step; with dir high channel B leads channel A.
  always @(posedge clk) if (resetn && step) ph_q <= dir ? ph_q + 2'h1 : ph_q - 2'h1;
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[0] ^ ph_q[1];
endmodule

// ===== tb/epm_top_sva.sv
// Port checker for the encoder position monitor.
`timescale 1ns/10ps
module epm_top_sva
  import epm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire epm_samples_t samples_in,
  input wire logic motor_stopped,
  input wire logic fault_clear,
  input wire logic [AMP_W-1:0] amp_lo,
  input wire logic [AMP_W-1:0] amp_hi,
  input wire logic [CNT_W-1:0] encoder_pulse_count,
  input wire logic [POS13_W-1:0] rotor_position_13bit,
  input wire logic [POS16_W-1:0] rotor_position_16bit,
  input wire logic [AMP_W-1:0] ab_pair_amplitude,
  input wire logic ab_synthesis_fault,
  input wire logic cd_synthesis_fault,
  input wire epm_samples_t samples_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_pos_one_step: assert property ($changed(rotor_position_13bit) |->
    (rotor_position_13bit - $past(rotor_position_13bit)) inside {13'h0001, 13'h1fff})
    else $error("position jumped");
  a_pos16_scaled: assert property (
    rotor_position_16bit == {rotor_position_13bit, 3'h0}) else $error("fine position off");
  a_count_tracks_pos: assert property (
    encoder_pulse_count[12:0] == rotor_position_13bit) else $error("counter off");
  a_sample_latch: assert property (sample_valid |=> samples_out == $past(samples_in))
    else $error("sample not latched");
  a_ab_window_fault: assert property (
    (ab_pair_amplitude < amp_lo || ab_pair_amplitude > amp_hi) |-> ##2 ab_synthesis_fault)
    else $error("ab fault missing");
  a_ab_fault_sticky: assert property (ab_synthesis_fault && !fault_clear |=> ab_synthesis_fault)
    else $error("ab fault dropped");
  a_cd_set_stopped: assert property ($rose(cd_synthesis_fault) |-> $past(motor_stopped))
    else $error("cd fault while moving");
  a_cd_fault_sticky: assert property (cd_synthesis_fault && !fault_clear |=> cd_synthesis_fault)
    else $error("cd fault dropped");
  c_ab_cleared: cover property ($fell(ab_synthesis_fault));
  c_cd_raised: cover property ($rose(cd_synthesis_fault));
  c_pos_wrap: cover property (rotor_position_13bit == 13'h1fff);
endmodule
bind epm_top epm_top_sva u_sva (.*);

// ===== tb/epm_top_tb.sv
// Self-checking bench for the encoder position monitor.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module epm_top_tb
  import epm_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, step = 1'b0, dir = 1'b0, enc_a, enc_b;
  logic sample_valid = 1'b0, motor_stopped = 1'b0, fault_clear = 1'b0;
  logic ab_synthesis_fault, cd_synthesis_fault;
  logic [2:0] uvw_in = 3'h0, commutation_state;
  logic [AMP_W-1:0] amp_lo = 25'h100, amp_hi = 25'h400000;
  logic [AMP_W-1:0] ab_pair_amplitude, cd_pair_amplitude;
  logic [15:0] enc_lines = 16'h0800, elec_angle_in = 16'h0000, electrical_angle_value;
  logic [15:0] no_load_tuning_check_value;
  logic [7:0] pole_pairs = 8'h0a;
  logic [CNT_W-1:0] encoder_pulse_count;
  logic [POS13_W-1:0] rotor_position_13bit;
  logic [POS16_W-1:0] rotor_position_16bit;
  epm_samples_t samples_in = '0, samples_out;
  int n_fail = 0;
  int compares = 0;
  epm_enc_model u_enc (.*);
  epm_top uut (.*);
  always #12.5 clk = ~clk;
  task automatic move(input int n, input logic d);
    repeat (n) begin
      @(posedge clk) step <= 1'b1;
      dir <= d;
      @(posedge clk) step <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic t_pos;
    move(4, 1'b1);
    `CHK(encoder_pulse_count, 32'h0000_0004)
    `CHK(rotor_position_16bit, 16'h0020)
    `CHK(rotor_position_13bit, 13'h0004)
    move(5, 1'b0);
    `CHK(encoder_pulse_count, 32'hffff_ffff)
    `CHK(rotor_position_13bit, 13'h1fff)
    move(1, 1'b1);
    `CHK(rotor_position_13bit, 13'h0000)
    $display("t_pos end");
  endtask
  task automatic t_samp;
    `CHK(ab_synthesis_fault, 1'b1)
    samples_in <= {12'h810, 12'h7f0, 12'h800, 12'h800};
    elec_angle_in <= 16'h1234;
    sample_valid <= 1'b1;
    @(posedge clk) sample_valid <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(samples_out, samples_in)
    `CHK(electrical_angle_value, 16'h1234)
    `CHK(ab_pair_amplitude, 25'h200)
    `CHK(cd_pair_amplitude, 25'h0)
    fault_clear <= 1'b1;
    @(posedge clk) fault_clear <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(ab_synthesis_fault, 1'b0)
    `CHK(cd_synthesis_fault, 1'b0)
    motor_stopped <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(cd_synthesis_fault, 1'b1)
    samples_in <= {12'h800, 12'h800, 12'hc00, 12'h800};
    sample_valid <= 1'b1;
    @(posedge clk) sample_valid <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(cd_pair_amplitude, 25'h100000)
    `CHK(ab_pair_amplitude, 25'h0)
    `CHK(ab_synthesis_fault, 1'b1)
    $display("t_samp end");
  endtask
  task automatic t_misc;
    uvw_in <= 3'h5;
    repeat (5) @(posedge clk);
    `CHK(commutation_state, 3'h5)
    `CHK(no_load_tuning_check_value, 16'h0088)
    $display("t_misc end");
  endtask
  task automatic finish_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_pos;
    t_samp;
    t_misc;
    finish_test;
  end
  // The whole sequence needs about 80 cycles; this limit leaves ample margin.
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule
